// ==== bench/rcf_reset_flags_test.sv ====
// Self-checking testbench of the reset-cause flag recorder
`timescale 1ns/1ps

module rcf_reset_flags_test import rcf_pkg::*;;

	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	rcf_evt_t evt = '0;
	rcf_bus_t bus = '0;
	logic [1:0] power_mode = MODE_FULL;
	logic [1:0] bo_cfg = BO_CFG_SOFT;
	logic sore = 1'b0;
	logic ieh = 1'b0;
	logic iel = 1'b0;
	logic [20:0] cur_pc = 21'h001234;
	logic [7:0] rdata;
	logic pc_load;
	logic [20:0] pc_value;
	logic core_reset;
	logic irq;
	int bad_count = 0;
	int tests_run = 0;
	int i;
	logic [20:0] exp_pc;

	// Event bit positions inside the packed event carrier
	localparam int E_RI = 6;
	localparam int E_BO = 5;
	localparam int E_MC = 4;
	localparam int E_WD = 3;
	localparam int E_SF = 2;
	localparam int E_SU = 1;
	localparam int E_WK = 0;

	// 40 MHz clock
	always #12.5 clock = ~clock;

	rcf_reset_flags i_rcf_reset_flags (
		.CLOCK(clock),
		.ARST_N(arst_n),
		.EVT(evt),
		.POWER_MODE(power_mode),
		.BROWNOUT_CONFIG_FIELD(bo_cfg),
		.STACK_OVERFLOW_RESET_ENABLE(sore),
		.IRQ_ENABLE_HIGH_PRIO(ieh),
		.IRQ_ENABLE_LOW_PRIO(iel),
		.CUR_PC(cur_pc),
		.BUS(bus),
		.RDATA(rdata),
		.PC_LOAD(pc_load),
		.PC_VALUE(pc_value),
		.CORE_RESET(core_reset),
		.IRQ(irq)
	);

	// ****************************************
	// Compare, report and bus tasks
	// ****************************************
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [20:0] got, input logic [20:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask

	// Read data is only valid in the cycle after the strobe; the task returns
	// on a rising edge so that level inputs set after it change on that edge
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge clock) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock) bus.rd <= 1'b0;
		@(negedge clock) chk({13'h0, rdata}, {13'h0, exp}, "read data");
		@(posedge clock);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock) bus.wr <= 1'b0;
	endtask

	// One event pulse, then the core control answer one edge later
	task automatic ev(input int b, input logic rst, input logic ld, input logic [20:0] pc,
		input bit ck_ld);
		@(posedge clock) evt <= rcf_evt_t'(7'h01 << b);
		@(posedge clock) evt <= '0;
		@(negedge clock);
		chk({20'h0, core_reset}, {20'h0, rst}, "core restart");
		if (ck_ld) begin
			chk({20'h0, pc_load}, {20'h0, ld}, "pc load");
		end
		if (ld) begin
			chk(pc_value, pc, "pc value");
		end
		// Return on a rising edge, where level inputs may change
		@(posedge clock);
	endtask

	// Interrupt line follows status and mask with one cycle of lag
	task automatic wirq(input logic exp);
		for (int k = 0; k < 4 && irq !== exp; k++) begin
			@(negedge clock);
		end
		chk({20'h0, irq}, {20'h0, exp}, "interrupt line");
	endtask

	// Hang guard, well above the length of the sequence
	initial begin
		#(25 * 20000);
		bad_count++;
		$display("unexpected at %0t: run did not finish", $time);
		stop_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		for (i = 0; i < 6 && core_reset !== 1'b1; i++) begin
			@(negedge clock);
		end
		chk({20'h0, core_reset}, 21'h1, "boot restart");
		chk(pc_value, PC_RESET, "boot pc");
		rd(ADDR_RESET_CAUSE, 8'h7C);
		rd(ADDR_STACK_PTR, 8'h00);
		wr(ADDR_RESET_CAUSE, 8'h00);
		rd(ADDR_RESET_CAUSE, 8'h0C);
		wr(ADDR_RESET_CAUSE, 8'h70);
		$display("test power-on done");
		ev(E_RI, 1'b1, 1'b1, PC_RESET, 1'b1);
		rd(ADDR_RESET_CAUSE, 8'h6C);
		wr(ADDR_RESET_CAUSE, 8'h41);
		ev(E_BO, 1'b1, 1'b1, PC_RESET, 1'b1);
		rd(ADDR_RESET_CAUSE, 8'h7C);
		ev(E_WD, 1'b1, 1'b1, PC_RESET, 1'b1);
		rd(ADDR_RESET_CAUSE, 8'h74);
		power_mode <= MODE_RUN;
		ev(E_MC, 1'b1, 1'b1, PC_RESET, 1'b1);
		rd(ADDR_RESET_CAUSE, 8'h7C);
		power_mode <= MODE_IDLE;
		ev(E_MC, 1'b1, 1'b1, PC_RESET, 1'b1);
		rd(ADDR_RESET_CAUSE, 8'h78);
		power_mode <= MODE_FULL;
		ev(E_MC, 1'b1, 1'b1, PC_RESET, 1'b1);
		rd(ADDR_RESET_CAUSE, 8'h78);
		power_mode <= MODE_SLEEP;
		ev(E_WD, 1'b0, 1'b1, 21'h001236, 1'b1);
		rd(ADDR_RESET_CAUSE, 8'h70);
		$display("test reset kinds done");
		power_mode <= MODE_FULL;
		sore <= 1'b1;
		wr(ADDR_STACK_PTR, 8'h15);
		ev(E_SF, 1'b1, 1'b1, PC_RESET, 1'b1);
		rd(ADDR_STACK_PTR, 8'h95);
		wr(ADDR_STACK_PTR, 8'h00);
		ev(E_SU, 1'b1, 1'b1, PC_RESET, 1'b1);
		rd(ADDR_STACK_PTR, 8'h40);
		wr(ADDR_STACK_PTR, 8'h00);
		sore <= 1'b0;
		ev(E_SU, 1'b0, 1'b0, PC_RESET, 1'b1);
		rd(ADDR_STACK_PTR, 8'h40);
		rd(ADDR_RESET_CAUSE, 8'h70);
		$display("test stack done");
		power_mode <= MODE_IDLE;
		for (i = 0; i < 4; i++) begin
			ieh <= i[0];
			iel <= i[1];
			exp_pc = i[0] ? VEC_HIGH : (i[1] ? VEC_LOW : 21'h001236);
			ev(E_BO, 1'b1, 1'b1, PC_RESET, 1'b1);
			ev(E_WK, 1'b0, 1'b1, exp_pc, 1'b1);
			rd(ADDR_RESET_CAUSE, 8'h78);
		end
		power_mode <= MODE_FULL;
		ev(E_WK, 1'b0, 1'b0, PC_RESET, 1'b1);
		bo_cfg <= 2'h0;
		ev(E_MC, 1'b1, 1'b1, PC_RESET, 1'b1);
		rd(ADDR_RESET_CAUSE, 8'h38);
		$display("test wake done");
		rd(ADDR_IRQ_STAT, 8'hFF);
		wirq(1'b0);
		wr(ADDR_IRQ_MASK, 8'h02);
		rd(ADDR_IRQ_MASK, 8'h02);
		wirq(1'b1);
		wr(ADDR_IRQ_STAT, 8'hFF);
		wirq(1'b0);
		rd(ADDR_IRQ_STAT, 8'h00);
		rd(12'h123, 8'h00);
		wr(12'h123, 8'h55);
		rd(ADDR_RESET_CAUSE, 8'h38);
		$display("test interrupt done");
		stop_test();
	end

endmodule // rcf_reset_flags_test

// ==== verilog/rcf_pkg.sv ====
// Constants, carriers and types of the reset-cause flag block
package rcf_pkg;

	// *****************************
	// Register offsets
	// *****************************
	localparam logic [11:0] ADDR_RESET_CAUSE = 12'hFD0;
	localparam logic [11:0] ADDR_STACK_PTR = 12'hFFC;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'hF00;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'hF01;

	// *****************************
	// Field positions
	// *****************************
	localparam int BIT_PRIO_EN = 7;
	localparam int BIT_SOFT_BO = 6;
	localparam int BIT_CFG_MIS = 5;
	localparam int BIT_RST_INSTR = 4;
	localparam int BIT_WDT_EXP = 3;
	localparam int BIT_PWRDN = 2;
	localparam int BIT_PWR_ON = 1;
	localparam int BIT_BROWNOUT = 0;
	localparam int BIT_STK_FULL = 7;
	localparam int BIT_STK_UNF = 6;
	localparam int SP_W = 5;

	// *****************************
	// Reset values and masks
	// *****************************
	localparam logic [7:0] RESET_CAUSE_INIT = 8'h3C;
	localparam logic [7:0] STACK_INIT = 8'h00;
	localparam logic [7:0] RC_SW_MASK = 8'hF3;
	localparam logic [7:0] STK_SW_MASK = 8'hDF;

	// *****************************
	// Program counter values
	// *****************************
	localparam int PC_W = 21;
	localparam logic [20:0] PC_RESET = 21'h000000;
	localparam logic [20:0] VEC_HIGH = 21'h000008;
	localparam logic [20:0] VEC_LOW = 21'h000018;
	localparam logic [20:0] PC_WAKE_STEP = 21'h000002;

	// *****************************
	// Modes, config and events
	// *****************************
	localparam logic [1:0] MODE_FULL = 2'h0;
	localparam logic [1:0] MODE_RUN = 2'h1;
	localparam logic [1:0] MODE_IDLE = 2'h2;
	localparam logic [1:0] MODE_SLEEP = 2'h3;
	localparam logic [1:0] BO_CFG_SOFT = 2'h1;
	localparam int NUM_EV = 8;
	localparam int EV_PWR_ON = 0;
	localparam int EV_BROWNOUT = 1;
	localparam int EV_RST_INSTR = 2;
	localparam int EV_MASTER_CLEAR_PIN = 3;
	localparam int EV_WDT = 4;
	localparam int EV_STK_FULL = 5;
	localparam int EV_STK_UNF = 6;
	localparam int EV_WAKE = 7;

	typedef struct packed {
		logic reset_instr;
		logic brownout;
		logic master_clear_pin;
		logic wdt_timeout;
		logic stack_full;
		logic stack_underflow;
		logic irq_wake;
	} rcf_evt_t;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rcf_bus_t;

	typedef enum logic [1:0] {
		ST_BOOT = 2'b01,
		ST_RUN = 2'b10
	} rcf_state_t;

endpackage

// ==== verilog/rcf_reset_flags.sv ====
// Reset-cause and stack flag recorder with program counter reload
//
// Function
// - Plain registers survive every reset except power-on
// - Watchdog wake-up leaves the stack register unchanged
// - Power-on: PC zero, preset flags, clear others
// - Reset instruction: PC zero, clear its flag
// - Brown-out: PC zero, set four, clear own
// - Pin reset in run mode sets expiry flag
// - Pin reset idle/sleep: expiry set, powerdown clear
// - Watchdog reset full/run: PC zero, clear expiry
// - Pin reset at full power: flags unchanged
// - Stack full with enable: reset, set flag
// - Stack underflow with enable: reset, set flag
// - Underflow without enable: flag only, no reset
// - Watchdog wake: PC plus 2, clear two
// - Interrupt wake: PC plus 2, clear powerdown
// - Interrupt wake with enable loads vector
// - Soft brown-out enable kept only in soft mode
`timescale 1ns/1ps

module rcf_reset_flags import rcf_pkg::*; (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic ARST_N,
	// Reset and wake events, one-cycle pulses
	input rcf_evt_t EVT,
	// Core state and configuration
	input wire logic [1:0] POWER_MODE,
	input wire logic [1:0] BROWNOUT_CONFIG_FIELD,
	input wire logic STACK_OVERFLOW_RESET_ENABLE,
	input wire logic IRQ_ENABLE_HIGH_PRIO,
	input wire logic IRQ_ENABLE_LOW_PRIO,
	input wire logic [20:0] CUR_PC,
	// Register port
	input rcf_bus_t BUS,
	output logic [7:0] RDATA,
	// Core control
	output logic PC_LOAD,
	output logic [20:0] PC_VALUE,
	output logic CORE_RESET,
	// Interrupt
	output logic IRQ
);

	// *****************************
	// Helpers
	// *****************************

	// Idle and sleep share the powerdown handling
	function automatic logic is_sleepy(input logic [1:0] m);
		is_sleepy = (m == MODE_IDLE) || (m == MODE_SLEEP);
	endfunction

	rcf_state_t state_r;
	logic [7:0] rc_r;
	logic [7:0] stk_r;
	logic [7:0] stat_r;
	logic [7:0] mask_r;
	logic [NUM_EV-1:0] win;
	logic [NUM_EV-1:0] ev;
	logic sleepy;
	logic stven;
	logic do_reset;
	logic wake;
	logic boot;
	logic wr_rc;
	logic wr_stk;
	logic soft_keep;

	assign sleepy = is_sleepy(POWER_MODE);
	assign stven = STACK_OVERFLOW_RESET_ENABLE;
	assign boot = (state_r == ST_BOOT);
	assign wr_rc = BUS.wr && (BUS.addr == ADDR_RESET_CAUSE);
	assign wr_stk = BUS.wr && (BUS.addr == ADDR_STACK_PTR);
	assign soft_keep = (BROWNOUT_CONFIG_FIELD == BO_CFG_SOFT) && rc_r[BIT_SOFT_BO];

	// *****************************
	// Boot sequencer
	// *****************************

	// One boot cycle after release; straps are sampled here, never in reset
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_r <= ST_BOOT;
		end else begin
			case (state_r)
				ST_BOOT: state_r <= ST_RUN;
				ST_RUN: state_r <= ST_RUN;
				default: state_r <= ST_BOOT;
			endcase
		end
	end

	// *****************************
	// Event arbitration
	// *****************************

	// One winner per cycle; brown-out outranks the pin and the watchdog
	always_comb begin
		win = '0;
		if (!boot) begin
			if (EVT.brownout) begin
				win[EV_BROWNOUT] = 1'b1;
			end else if (EVT.master_clear_pin) begin
				win[EV_MASTER_CLEAR_PIN] = 1'b1;
			end else if (EVT.wdt_timeout) begin
				win[EV_WDT] = 1'b1;
			end else if (EVT.reset_instr) begin
				win[EV_RST_INSTR] = 1'b1;
			end else if (EVT.stack_full) begin
				win[EV_STK_FULL] = 1'b1;
			end else if (EVT.stack_underflow) begin
				win[EV_STK_UNF] = 1'b1;
			end else if (EVT.irq_wake && POWER_MODE != MODE_FULL) begin
				win[EV_WAKE] = 1'b1;
			end
		end
	end

	// Stack events only restart the core when the enable is set
	assign do_reset = win[EV_BROWNOUT] | win[EV_MASTER_CLEAR_PIN] | win[EV_RST_INSTR]
		| (win[EV_WDT] & ~sleepy)
		| ((win[EV_STK_FULL] | win[EV_STK_UNF]) & stven);
	assign wake = win[EV_WAKE] | (win[EV_WDT] & sleepy);

	// *****************************
	// Reset cause register
	// *****************************

	// Software write first; hardware effects below override it
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			rc_r <= RESET_CAUSE_INIT;
		end else begin
			if (wr_rc) begin
				rc_r <= (BUS.wdata & RC_SW_MASK) | (rc_r & ~RC_SW_MASK);
			end
			if (boot) begin
				// Power-on: soft enable on only in soft mode
				rc_r[BIT_SOFT_BO] <= (BROWNOUT_CONFIG_FIELD == BO_CFG_SOFT);
			end else if (do_reset && !soft_keep) begin
				rc_r[BIT_SOFT_BO] <= 1'b0;
			end
			if (win[EV_BROWNOUT]) begin
				rc_r[BIT_CFG_MIS] <= 1'b1;
				rc_r[BIT_RST_INSTR] <= 1'b1;
				rc_r[BIT_WDT_EXP] <= 1'b1;
				rc_r[BIT_PWRDN] <= 1'b1;
				rc_r[BIT_BROWNOUT] <= 1'b0;
			end
			if (win[EV_RST_INSTR]) begin
				rc_r[BIT_RST_INSTR] <= 1'b0;
			end
			// Pin reset at full power touches no flag below the soft enable bit
			if (win[EV_MASTER_CLEAR_PIN] && sleepy) begin
				rc_r[BIT_WDT_EXP] <= 1'b1;
				rc_r[BIT_PWRDN] <= 1'b0;
			end else if (win[EV_MASTER_CLEAR_PIN] && POWER_MODE == MODE_RUN) begin
				rc_r[BIT_WDT_EXP] <= 1'b1;
			end
			if (win[EV_WDT]) begin
				rc_r[BIT_WDT_EXP] <= 1'b0;
			end
			if (win[EV_WDT] && sleepy) begin
				rc_r[BIT_PWRDN] <= 1'b0;
			end
			// Interrupt wake-ups are resumption: only powerdown changes
			if (win[EV_WAKE]) begin
				rc_r[BIT_PWRDN] <= 1'b0;
			end
		end
	end

	// *****************************
	// Stack pointer register
	// *****************************

	// Pointer bits survive all but power-on; hardware set beats clear
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			stk_r <= STACK_INIT;
		end else begin
			if (wr_stk) begin
				stk_r <= BUS.wdata & STK_SW_MASK;
			end
			if (win[EV_STK_FULL]) begin
				stk_r[BIT_STK_FULL] <= 1'b1;
			end
			if (win[EV_STK_UNF]) begin
				stk_r[BIT_STK_UNF] <= 1'b1;
			end
		end
	end

	// *****************************
	// Program counter control
	// *****************************

	// Restart vector, wake address or interrupt vector
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			PC_LOAD <= 1'b0;
			PC_VALUE <= PC_RESET;
			CORE_RESET <= 1'b0;
		end else begin
			PC_LOAD <= boot | do_reset | wake;
			CORE_RESET <= boot | do_reset;
			if (boot || do_reset) begin
				PC_VALUE <= PC_RESET;
			end else if (win[EV_WAKE] && IRQ_ENABLE_HIGH_PRIO) begin
				PC_VALUE <= VEC_HIGH;
			end else if (win[EV_WAKE] && IRQ_ENABLE_LOW_PRIO) begin
				PC_VALUE <= VEC_LOW;
			end else if (wake) begin
				PC_VALUE <= CUR_PC + PC_WAKE_STEP;
			end
		end
	end

	// *****************************
	// Interrupt status and mask
	// *****************************

	// Boot counts as the power-on event
	always_comb begin
		ev = win;
		ev[EV_PWR_ON] = boot;
	end

	// Write one to clear; a new event in the same cycle wins
	generate
		for (genvar i = 0; i < NUM_EV; i++) begin : g_stat
			always_ff @(posedge CLOCK or negedge ARST_N) begin
				if (!ARST_N) begin
					stat_r[i] <= 1'b0;
				end else if (ev[i]) begin
					stat_r[i] <= 1'b1;
				end else if (BUS.wr && BUS.addr == ADDR_IRQ_STAT && BUS.wdata[i]) begin
					stat_r[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// Mask is plain storage
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			mask_r <= 8'h00;
		end else if (BUS.wr && BUS.addr == ADDR_IRQ_MASK) begin
			mask_r <= BUS.wdata;
		end
	end

	// Registered level; lags status by one cycle
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(stat_r & mask_r);
		end
	end

	// *****************************
	// Read port
	// *****************************

	// Data stand one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge CLOCK or negedge ARST_N) begin
		if (!ARST_N) begin
			RDATA <= 8'h00;
		end else if (BUS.rd) begin
			case (BUS.addr)
				ADDR_RESET_CAUSE: RDATA <= rc_r;
				ADDR_STACK_PTR: RDATA <= stk_r;
				ADDR_IRQ_STAT: RDATA <= stat_r;
				ADDR_IRQ_MASK: RDATA <= mask_r;
				default: RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	// *****************************
	// Assertions
	// *****************************

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!ARST_N);

	property p_boot;
		boot && ARST_N |=> CORE_RESET && PC_LOAD && PC_VALUE == PC_RESET
			&& rc_r[BIT_SOFT_BO] == ($past(BROWNOUT_CONFIG_FIELD) == BO_CFG_SOFT);
	endproperty
	a_boot: assert property (p_boot) else $error("boot load wrong");

	property p_bo;
		win[EV_BROWNOUT] |=> rc_r[5:2] == 4'hF && !rc_r[BIT_BROWNOUT]
			&& rc_r[BIT_PWR_ON] == $past(rc_r[BIT_PWR_ON]) && CORE_RESET;
	endproperty
	a_bo: assert property (p_bo) else $error("brown-out flags wrong");

	property p_ri;
		win[EV_RST_INSTR] && !wr_rc |=> !rc_r[BIT_RST_INSTR]
			&& rc_r[3:0] == $past(rc_r[3:0]) && PC_VALUE == PC_RESET;
	endproperty
	a_ri: assert property (p_ri) else $error("reset instr flags wrong");

	property p_master_clear_pin_full;
		win[EV_MASTER_CLEAR_PIN] && POWER_MODE == MODE_FULL && !wr_rc
			|=> rc_r[5:0] == $past(rc_r[5:0]) && PC_LOAD;
	endproperty
	a_master_clear_pin_full: assert property (p_master_clear_pin_full) else $error("pin reset changed flags");

	property p_master_clear_pin_sleep;
		win[EV_MASTER_CLEAR_PIN] && sleepy |=> rc_r[BIT_WDT_EXP] && !rc_r[BIT_PWRDN];
	endproperty
	a_master_clear_pin_sleep: assert property (p_master_clear_pin_sleep) else $error("pin reset sleep wrong");

	property p_wdt_full;
		win[EV_WDT] && !sleepy |=> !rc_r[BIT_WDT_EXP] && CORE_RESET;
	endproperty
	a_wdt_full: assert property (p_wdt_full) else $error("watchdog reset wrong");

	property p_wdt_wake;
		win[EV_WDT] && sleepy |=> !rc_r[BIT_WDT_EXP] && !rc_r[BIT_PWRDN]
			&& !CORE_RESET && PC_VALUE == $past(CUR_PC) + PC_WAKE_STEP;
	endproperty
	a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

	property p_stk_full;
		win[EV_STK_FULL] && stven |=> stk_r[BIT_STK_FULL] && CORE_RESET;
	endproperty
	a_stk_full: assert property (p_stk_full) else $error("stack full reset wrong");

	property p_unf_soft;
		win[EV_STK_UNF] && !stven |=> stk_r[BIT_STK_UNF] && !CORE_RESET && !PC_LOAD;
	endproperty
	a_unf_soft: assert property (p_unf_soft) else $error("underflow error wrong");

	property p_vec;
		win[EV_WAKE] && IRQ_ENABLE_HIGH_PRIO |=> PC_VALUE == VEC_HIGH && !rc_r[BIT_PWRDN];
	endproperty
	a_vec: assert property (p_vec) else $error("wake vector wrong");

	property p_irq;
		(stat_r & mask_r) != 8'h00 |=> IRQ;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

	c_bo: cover property (win[EV_BROWNOUT] ##1 CORE_RESET);
	c_wake: cover property (win[EV_WAKE] ##1 PC_LOAD);
	c_irq_clr: cover property (IRQ ##1 !IRQ);

endmodule // rcf_reset_flags
